// >>> hdl/tmds_rx_defines.svh
`ifndef TMDS_RX_DEFINES_SVH
`define TMDS_RX_DEFINES_SVH
`define CORE_CLK_NS 40
`define REF_PERIOD_NS 320
`define STAGGER_NS (`REF_PERIOD_NS / 4)
`define STAGGER_CYC ((`STAGGER_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define PD_HIZ_NS 9
`define PD_HIZ_CYC (((`PD_HIZ_NS / `CORE_CLK_NS) < 1) ? 1 : (`PD_HIZ_NS / `CORE_CLK_NS))
`define SYNC_STAGES 2
`define LOSS_PIX 1000000
`define ACQ_PIX 1600
`define IDLE_W 20
`define ACQ_W 11
`define CHAR_W 10
`define REG_CTRL 32'h0000_0000
`define REG_STAT 32'h0000_0004
`define CTRL_W 4
`define CTRL_RESET 4'h4
`define CTRL_DUAL 0
`define CTRL_EDGE 1
`define CTRL_STAGGER_SELECT_N_N 2
`define CTRL_DRIVE 3
`define CTL_CODE_00 10'h354
`define CTL_CODE_01 10'h0ab
`define CTL_CODE_10 10'h154
`define CTL_CODE_11 10'h2ab
`endif

// >>> hdl/tmds_rx_pkg.sv
`include "tmds_rx_defines.svh"
package tmds_rx_pkg;
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } rgb_s;

   typedef logic [2:0][`CHAR_W-1:0] chars_t;

   typedef struct packed {
      logic ref1;
      logic ref2;
      logic ref3;
      chars_t din1;
      chars_t din2;
      chars_t prev;
      logic [2:0] dly;
      logic de;
      logic hsync;
      logic vsync;
      logic [2:0] ctl;
      rgb_s even;
      rgb_s odd;
      rgb_s first;
      rgb_s pend;
      logic [1:0] pend_cnt;
      logic phase;
      logic ock;
      logic flag;
      logic [`IDLE_W-1:0] idle;
      logic [`ACQ_W-1:0] acq;
      logic gpd1;
      logic gpd2;
      logic opd1;
      logic opd2;
      logic oe_data;
      logic oe_keep;
      logic [`CTRL_W-1:0] cfg;
      logic wr_pend;
      logic rdy;
      logic [31:0] rdata;
   } rx_state_s;
endpackage

// >>> hdl/tmds_rx_decode.sv
`timescale 1ns/1ps
`include "tmds_rx_defines.svh"
module tmds_rx_decode #(
   parameter int LOSS_PIX = `LOSS_PIX,
   parameter int ACQ_PIX = `ACQ_PIX
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // ahb-lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // link side: reference clock and recovered characters
   input wire logic link_ref_clock,
   input wire tmds_rx_pkg::chars_t link_chars,
   // power-down pins
   input wire logic global_powerdown_n,
   input wire logic output_powerdown_n,
   // parallel outputs
   output logic pixel_out_clock,
   output tmds_rx_pkg::rgb_s even_pixel_bus,
   output tmds_rx_pkg::rgb_s odd_pixel_bus,
   output logic data_enable,
   output logic hsync,
   output logic vsync,
   output logic [2:0] user_controls,
   output logic link_active_flag,
   output logic drive_strength_select,
   // output enables: data group, and the group kept alive by output power-down
   output logic data_oe,
   output logic keep_oe
);
   localparam int PD_BOUND = `SYNC_STAGES + `PD_HIZ_CYC + 1;

   tmds_rx_pkg::rx_state_s s;
   tmds_rx_pkg::rx_state_s n;

   // control characters carry two bits each
   function automatic logic is_ctl(input logic [`CHAR_W-1:0] q);
      return (q == `CTL_CODE_00) || (q == `CTL_CODE_01) ||
             (q == `CTL_CODE_10) || (q == `CTL_CODE_11);
   endfunction

   function automatic logic [1:0] dec_ctl(input logic [`CHAR_W-1:0] q);
      logic [1:0] c;
      c = 2'h0;
      if (q == `CTL_CODE_01) c = 2'h1;
      if (q == `CTL_CODE_10) c = 2'h2;
      if (q == `CTL_CODE_11) c = 2'h3;
      return c;
   endfunction

   // undo the optional inversion, then the xor/xnor chain
   function automatic logic [7:0] dec_pix(input logic [`CHAR_W-1:0] q);
      logic [7:0] d;
      logic [7:0] o;
      d = q[9] ? ~q[7:0] : q[7:0];
      o[0] = d[0];
      for (int i = 1; i < 8; i++) begin
         o[i] = q[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
      end
      return o;
   endfunction

   logic step;
   logic dual;
   logic edge_sel;
   logic stagger_select_n_n;
   logic addr_ph;
   tmds_rx_pkg::chars_t ali;
   logic [2:0] raw_ctl;
   logic de_new;
   logic de_trans;
   tmds_rx_pkg::rgb_s pix;
   logic [1:0] c0;
   logic [1:0] c1;
   logic [1:0] c2;

   // one pixel step per rising edge of the sampled reference clock
   assign step = s.ref2 & ~s.ref3;
   assign dual = s.cfg[`CTRL_DUAL];
   assign edge_sel = s.cfg[`CTRL_EDGE];
   assign stagger_select_n_n = s.cfg[`CTRL_STAGGER_SELECT_N_N];
   assign addr_ph = hsel & htrans[1] & hready;

   // realign channels: a channel that changes class a pixel early is held back one
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         raw_ctl[c] = is_ctl(s.din2[c]);
         ali[c] = s.dly[c] ? s.prev[c] : s.din2[c];
      end
      de_new = ~is_ctl(ali[0]);
      de_trans = de_new != s.de;
      pix.red = dec_pix(ali[2]);
      pix.green = dec_pix(ali[1]);
      pix.blue = dec_pix(ali[0]);
      c0 = dec_ctl(ali[0]);
      c1 = dec_ctl(ali[1]);
      c2 = dec_ctl(ali[2]);
   end

   // next-state logic for the whole block
   always_comb begin
      n = s;
      // link clock and characters come from another domain: two flops first
      n.ref1 = link_ref_clock;
      n.ref2 = s.ref1;
      n.ref3 = s.ref2;
      n.din1 = link_chars;
      n.din2 = s.din1;
      n.gpd1 = global_powerdown_n;
      n.gpd2 = s.gpd1;
      n.opd1 = output_powerdown_n;
      n.opd2 = s.opd1;
      // power-down: global kills all drivers, output power-down spares the keep group
      n.oe_keep = s.gpd2;
      n.oe_data = s.gpd2 & s.opd2;
      // staggered even bus lands a quarter pixel after the odd bus
      if (s.pend_cnt != 2'h0) begin
         n.pend_cnt = s.pend_cnt - 2'h1;
         if (s.pend_cnt == 2'h1) begin
            n.even = s.pend;
         end
      end
      // single mode: output clock follows the reference, inverted for rising capture
      if (!dual) begin
         n.ock = s.ref2 ^ edge_sel;
      end
      if (step) begin
         n.prev = s.din2;
         // skew fix is learned where the classes disagree across channels
         if (raw_ctl != 3'h0 && raw_ctl != 3'h7) begin
            n.dly = s.de ? raw_ctl : ~raw_ctl;
         end
         n.de = de_new;
         if (de_new) begin
            if (!dual) begin
               n.even = pix;
               n.ock = 1'b1 ^ edge_sel;
            end else if (!s.phase || !s.de) begin
               n.first = pix;
               n.phase = 1'b1;
               n.ock = 1'b0 ^ edge_sel;
            end else begin
               n.phase = 1'b0;
               n.odd = pix;
               n.ock = 1'b1 ^ edge_sel;
               if (!stagger_select_n_n) begin
                  n.pend = s.first;
                  n.pend_cnt = 2'(`STAGGER_CYC);
               end else begin
                  n.even = s.first;
               end
            end
         end else begin
            // blanking: syncs and user controls 3..1 only; control 0 dropped
            n.hsync = c0[0];
            n.vsync = c0[1];
            n.ctl = {c2[1], c2[0], c1[1]};
            n.phase = 1'b0;
            if (dual) begin
               n.ock = ~s.ock;
            end
         end
         // link activity from the spacing of data enable transitions
         if (de_trans) begin
            n.idle = '0;
         end else if (s.idle < `IDLE_W'(LOSS_PIX)) begin
            n.idle = s.idle + `IDLE_W'(1);
         end
         if (s.flag) begin
            if (!de_trans && s.idle == `IDLE_W'(LOSS_PIX - 1)) begin
               n.flag = 1'b0;
               n.acq = '0;
            end
         end else if (de_trans || s.idle < `IDLE_W'(LOSS_PIX)) begin
            n.acq = s.acq + `ACQ_W'(1);
            if (s.acq == `ACQ_W'(ACQ_PIX - 1)) begin
               n.flag = 1'b1;
            end
         end else begin
            n.acq = '0;
         end
      end
      // ahb-lite: zero wait states, read data staged in the address phase
      n.rdy = 1'b1;
      if (s.wr_pend) begin
         n.cfg = hwdata[`CTRL_W-1:0];
      end
      n.wr_pend = 1'b0;
      if (addr_ph) begin
         n.wr_pend = hwrite && (haddr == `REG_CTRL);
         n.rdata = 32'h0;
         if (!hwrite && haddr == `REG_CTRL) begin
            n.rdata = {28'h0, s.cfg};
         end
         if (!hwrite && haddr == `REG_STAT) begin
            n.rdata = {27'h0, s.dly, s.de, s.flag};
         end
      end
   end

   // state register: synchronous reset, clock enable freezes everything
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
         s.cfg <= `CTRL_RESET;
         s.rdy <= 1'b1;
         s.idle <= `IDLE_W'(LOSS_PIX);
      end else if (ce) begin
         s <= n;
      end
   end

   // every output straight from a state flop
   assign hreadyout = s.rdy;
   assign hresp = 1'b0 & s.rdy;
   assign hrdata = s.rdata;
   assign pixel_out_clock = s.ock;
   assign even_pixel_bus = s.even;
   assign odd_pixel_bus = s.odd;
   assign data_enable = s.de;
   assign hsync = s.hsync;
   assign vsync = s.vsync;
   assign user_controls = s.ctl;
   assign link_active_flag = s.flag;
   assign drive_strength_select = s.cfg[`CTRL_DRIVE];
   assign data_oe = s.oe_data;
   assign keep_oe = s.oe_keep;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst || !ce);

   // closing step of a dual-mode pair, reused by the pair checks
   sequence pair_done;
      step && dual && de_new && s.phase && s.de;
   endsequence

   sequence stagger_select_n_wait;
      ##(`STAGGER_CYC) 1'b1;
   endsequence

   // output clock shape in both pixel modes
   out_clk_single_a: assert property (
      !dual && !step |=> pixel_out_clock == ($past(s.ref2) ^ $past(edge_sel)))
      else $error("single-mode output clock does not follow reference");

   dual_clk_blank_a: assert property (
      step && dual && !de_new |=> pixel_out_clock != $past(pixel_out_clock))
      else $error("dual-mode output clock did not toggle in blanking");

   dual_latch_edge_a: assert property (
      pair_done |=> pixel_out_clock == !edge_sel && odd_pixel_bus == $past(pix))
      else $error("dual-mode pair not aligned with latching edge");

   // pair building and the staggered even bus
   dual_first_a: assert property (
      step && dual && de_new && (!s.phase || !s.de) |=> s.phase && s.first == $past(pix))
      else $error("first pixel of a pair not held for the even bus");

   stagger_even_a: assert property (
      pair_done ##0 !stagger_select_n_n |-> ##1 $stable(even_pixel_bus) ##0 stagger_select_n_wait
      ##0 even_pixel_bus == $past(s.first, `STAGGER_CYC + 1))
      else $error("staggered even bus not a quarter pixel late");

   stagger_select_n_off_a: assert property (
      pair_done ##0 stagger_select_n_n |=> even_pixel_bus == $past(s.first))
      else $error("unstaggered even bus not output with the odd bus");

   // character classing and channel mapping
   de_pixel_a: assert property (
      step && !is_ctl(ali[0]) |=> data_enable)
      else $error("pixel character did not raise data enable");

   de_control_a: assert property (
      step && is_ctl(ali[0]) |=> !data_enable)
      else $error("control character did not lower data enable");

   pix_map_a: assert property (
      step && !dual && de_new |=> even_pixel_bus.red == $past(dec_pix(ali[2]))
      && even_pixel_bus.green == $past(dec_pix(ali[1]))
      && even_pixel_bus.blue == $past(dec_pix(ali[0])))
      else $error("pixel channels not mapped to red, green and blue");

   // a late channel is learned only where classes disagree
   skew_learn_a: assert property (
      step && !s.de && raw_ctl != 3'h0 && raw_ctl != 3'h7 |=> s.dly == ~$past(raw_ctl))
      else $error("early channels not delayed at data enable rise");

   // link activity
   link_loss_a: assert property (
      s.flag && step && !de_trans && s.idle == `IDLE_W'(LOSS_PIX - 1)
      |=> !link_active_flag && s.acq == '0)
      else $error("link flag not dropped after idle limit");

   link_acq_a: assert property (
      !s.flag && step && s.acq == `ACQ_W'(ACQ_PIX - 1) && s.idle < `IDLE_W'(LOSS_PIX)
      |=> link_active_flag)
      else $error("link flag not raised after acquisition count");

   flag_step_a: assert property (
      !step |=> $stable(link_active_flag))
      else $error("link flag moved between pixel steps");

   idle_clear_a: assert property (
      step && de_trans |=> s.idle == '0)
      else $error("idle span not restarted by a data enable transition");

   // power-down
   pd_global_a: assert property (
      $fell(global_powerdown_n) ##1 !global_powerdown_n [*3]
      |-> ##[0:PD_BOUND] !data_oe && !keep_oe)
      else $error("global power-down did not release outputs");

   pd_output_a: assert property (
      $fell(output_powerdown_n) && s.gpd2 && global_powerdown_n
      ##1 (!output_powerdown_n && global_powerdown_n) [*3]
      |-> ##[0:PD_BOUND] !data_oe && keep_oe)
      else $error("output power-down did not release data drivers");

   pd_keep_a: assert property (
      s.gpd2 && s.opd2 |=> data_oe && keep_oe)
      else $error("drivers not enabled with both power-down pins high");

   // controls during active data, the odd pixel bus during blanking
   ctl_hold_a: assert property (
      data_enable && $past(data_enable) |-> $stable(user_controls) && $stable(hsync)
      && $stable(vsync))
      else $error("controls changed during active data");

   pix_hold_a: assert property (
      !data_enable && $past(!data_enable) && s.pend_cnt == 2'h0
      |-> $stable(odd_pixel_bus))
      else $error("pixel bus changed during blanking");

   ctl_map_a: assert property (
      step && !de_new |=> user_controls == {$past(c2), $past(c1[1])}
      && hsync == $past(c0[0]))
      else $error("control character mapping wrong");

   // mode bits land one cycle after their data phase
   ctrl_write_a: assert property (
      addr_ph && hwrite && haddr == `REG_CTRL |-> ##2 s.cfg == $past(hwdata[`CTRL_W-1:0]))
      else $error("mode register write did not land");
endmodule

// >>> tb/host_tx_model.sv
`timescale 1ns/1ps
`include "tmds_rx_defines.svh"
module host_tx_model (
   // link towards the receiver
   output logic link_ref_clock,
   output tmds_rx_pkg::chars_t link_chars,
   // channels sent one pixel late, as over a skewed cable
   input wire logic [2:0] skew
);
   localparam logic [9:0] codes [4] = '{`CTL_CODE_00, `CTL_CODE_01, `CTL_CODE_10, `CTL_CODE_11};
   int disp [3] = '{0, 0, 0};
   tmds_rx_pkg::chars_t prev;

   // the source clock runs free; the link opens in blanking
   initial begin
      link_ref_clock = 1'b0;
      link_chars = {3{codes[0]}};
      prev = link_chars;
   end
   always #(`REF_PERIOD_NS / 2) link_ref_clock = ~link_ref_clock;

   // eight bits to ten; the disparity count picks which of two forms goes out
   function automatic logic [9:0] enc(input logic [7:0] d, inout int cnt);
      logic [8:0] m;
      logic x;
      int n;
      x = $countones(d) > 4 || ($countones(d) == 4 && !d[0]);
      m[0] = d[0];
      for (int i = 1; i < 8; i++) begin
         m[i] = m[i-1] ^ d[i] ^ x;
      end
      m[8] = !x;
      n = $countones(m[7:0]) - 4;
      if (cnt == 0 || n == 0) begin
         enc = {!m[8], m[8], m[8] ? m[7:0] : ~m[7:0]};
         cnt += m[8] ? 2 * n : -2 * n;
      end else if ((cnt > 0) == (n > 0)) begin
         enc = {1'b1, m[8], ~m[7:0]};
         cnt += 2 * m[8] - 2 * n;
      end else begin
         enc = {1'b0, m[8], m[7:0]};
         cnt += 2 * n - 2 * !m[8];
      end
   endfunction

   // one triple per period, changed at the falling edge, away from sampling
   task automatic send(input tmds_rx_pkg::chars_t c);
      tmds_rx_pkg::chars_t o;
      for (int i = 0; i < 3; i++) begin
         o[i] = skew[i] ? prev[i] : c[i];
      end
      @(negedge link_ref_clock);
      link_chars <= o;
      prev = c;
   endtask

   // pixel: red on channel 2, green on 1, blue on 0
   task automatic pix(input tmds_rx_pkg::rgb_s p);
      send({enc(p.red, disp[2]), enc(p.green, disp[1]), enc(p.blue, disp[0])});
   endtask

   // blanking: two control bits per channel, disparity restarts
   task automatic ctl(input logic [5:0] v);
      disp = '{0, 0, 0};
      send({codes[v[5:4]], codes[v[3:2]], codes[v[1:0]]});
   endtask
endmodule

// >>> tb/tmds_receiver_decode_output_tb.sv
`timescale 1ns/1ps
`include "tmds_rx_defines.svh"
module tmds_receiver_decode_output_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic global_powerdown_n = 1'b1;
   logic output_powerdown_n = 1'b1;
   logic [2:0] skew = 3'h0;
   logic hreadyout, hresp, pixel_out_clock, data_enable, hsync, vsync, link_ref_clock;
   logic link_active_flag, drive_strength_select, data_oe, keep_oe, ock_l, de_p, pde;
   logic [2:0] user_controls;
   logic [3:0] cfg = 4'h4;
   logic [5:0] v;
   logic [31:0] hrdata, rd;
   logic [31:0] rnd = 32'h27;
   logic [3:0] modes [6] = '{4'h6, 4'h5, 4'h1, 4'h3, 4'h7, 4'h4};
   tmds_rx_pkg::chars_t link_chars;
   tmds_rx_pkg::rgb_s even_pixel_bus, odd_pixel_bus, ev_p, od_p, p;
   tmds_rx_pkg::rgb_s exp_q [$];
   int fail_count = 0;
   int comparisons = 0;
   int per = 0;
   int lcnt = 0;
   bit chk = 1'b0;

   always #20 core_clk = ~core_clk;

   // short link-detect spans keep the run brief
   tmds_rx_decode #(.LOSS_PIX(256), .ACQ_PIX(16)) i_dut (
      .core_clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .link_ref_clock, .link_chars,
      .global_powerdown_n, .output_powerdown_n, .pixel_out_clock, .even_pixel_bus,
      .odd_pixel_bus, .data_enable, .hsync, .vsync, .user_controls, .link_active_flag,
      .drive_strength_select, .data_oe, .keep_oe
   );
   host_tx_model i_host (.link_ref_clock, .link_chars, .skew);

   // comparison and verdict
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // shifted 24 times so each draw is fresh
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int i = 0; i < 24; i++) begin
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      end
      return s;
   endfunction

   // single word transfer; waits for the slave, never assumes a latency
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      cmp(hresp, 1'b0, "okay");
   endtask
   task automatic set_cfg(input logic [3:0] c);
      ahb(1'b1, `REG_CTRL, {28'h0, c});
      cfg = c;
   endtask
   task automatic blank(input int n, input logic [5:0] c);
      repeat (n) i_host.ctl(c);
   endtask
   task automatic line(input int n, input int b);
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         p = rnd[23:0];
         if (chk) exp_q.push_back(p);
         i_host.pix(p);
      end
      blank(b, 6'h0);
      if (chk && !cfg[`CTRL_DUAL] && b > 0) cmp(even_pixel_bus, p, "held");
   endtask

   // a panel's view: latch on the selected edge what stood just before it
   always @(posedge core_clk) begin
      per++;
      if (pixel_out_clock !== ock_l && pixel_out_clock !== cfg[`CTRL_EDGE]) lcnt = 0;
      if (chk && data_enable === 1'b1 && even_pixel_bus !== ev_p) begin
         cmp(lcnt, (cfg[`CTRL_DUAL] && !cfg[`CTRL_STAGGER_SELECT_N_N]) ? `STAGGER_CYC : 0, "lag");
      end
      if (pixel_out_clock === cfg[`CTRL_EDGE] && ock_l !== cfg[`CTRL_EDGE]) begin
         if (chk && de_p === 1'b1) begin
            if (pde === 1'b1) cmp(per, cfg[`CTRL_DUAL] ? 16 : 8, "period");
            cmp(ev_p, exp_q.pop_front(), "even");
            if (cfg[`CTRL_DUAL]) cmp(od_p, exp_q.pop_front(), "odd");
         end
         pde = de_p;
         per = 0;
      end
      lcnt++;
      ock_l = pixel_out_clock;
      de_p = data_enable;
      ev_p = even_pixel_bus;
      od_p = odd_pixel_bus;
   end

   // a hang ends the run the same way
   initial begin
      #2000000;
      fail_count++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      ahb(1'b0, `REG_CTRL, 32'h0);
      cmp(rd, `CTRL_RESET, "ctrl reset");
      rnd = lfsr(rnd);
      ahb(1'b1, `REG_CTRL, rnd);
      ahb(1'b1, `REG_STAT, 32'hffff_ffff);
      ahb(1'b0, `REG_CTRL, 32'h0);
      cmp(rd, rnd[3:0], "ctrl rw");
      cmp(drive_strength_select, rnd[`CTRL_DRIVE], "drive");
      ahb(1'b0, `REG_STAT, 32'h0);
      cmp(rd, 32'h0, "stat ro");
      ahb(1'b0, 32'h40, 32'h0);
      cmp(rd, 32'h0, "unmapped");
      set_cfg(4'h4);
      blank(128, 6'h0);
      // every code on every channel, then random controls
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         v = (i < 4) ? {3{i[1:0]}} : rnd[5:0];
         blank(3, v);
         cmp({user_controls, vsync, hsync}, {v[5:3], v[1:0]}, "ctl");
      end
      cmp(link_active_flag, 1'b0, "flag idle");
      chk = 1'b1;
      line(8, 0);
      cmp(link_active_flag, 1'b0, "flag early");
      line(8, 128);
      cmp(link_active_flag, 1'b1, "flag up");
      foreach (modes[i]) begin
         set_cfg(modes[i]);
         blank(8, 6'h0);
         line(16, 128);
         cmp(exp_q.size(), 32'h0, "count");
      end
      // a late channel, then two; first line lets the aligner settle
      for (int i = 1; i < 7; i += 5) begin
         skew <= i[2:0];
         chk = 1'b0;
         line(16, 128);
         chk = 1'b1;
         line(16, 128);
         cmp(exp_q.size(), 32'h0, "skew");
      end
      // global, then output power-down, each released
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         global_powerdown_n <= i != 0;
         output_powerdown_n <= i != 2;
         repeat (4) @(posedge core_clk);
         cmp({data_oe, keep_oe}, i[0] ? 2'h3 : {1'b0, i[1]}, "oe");
      end
      // clock enable low must freeze the output clock, data_oe, the link flag and the even bus
      @(posedge core_clk);
      ce <= 1'b0;
      @(posedge core_clk);
      rd = {pixel_out_clock, data_oe, link_active_flag, even_pixel_bus};
      repeat (20) @(posedge core_clk);
      cmp({pixel_out_clock, data_oe, link_active_flag, even_pixel_bus}, rd, "frozen");
      ce <= 1'b1;
      chk = 1'b0;
      line(16, 200);
      cmp(link_active_flag, 1'b1, "flag kept");
      blank(80, 6'h0);
      cmp(link_active_flag, 1'b0, "flag lost");
      stop_test();
   end
endmodule
